// ==== rtl/svd_map.svh ====
// offsets, field positions, reset values and timing counts of the decoder
// assumes inclusion by bare name from the package; the decoder module sees its macros from there
`ifndef SVD_MAP_SVH
`define SVD_MAP_SVH

// apb register byte offsets
`define SVD_CTRL_OFS 12'h000
`define SVD_STAT_OFS 12'h004
`define SVD_CORE_OFS 12'h008
`define SVD_NB_OFS 12'h00c
`define SVD_RAW_OFS 12'h010
`define SVD_ID_OFS 12'h014

// control register fields
`define SVD_CTRL_CORE3PH 0
`define SVD_CTRL_NB2PH 1
`define SVD_CTRL_RESET 32'h0000_0003

// packet layout: 27 bit positions, first bit is position 1
`define SVD_PKT_BITS 27
`define SVD_HDR_PATTERN 5'h18
`define SVD_CODE_OFF_MIN 8'hf8
`define SVD_CODE_RESET 8'h00
`define SVD_CORE_PH_RESET 3'b111
`define SVD_NB_PH_RESET 2'b11

// arbitrary identification value
`define SVD_ID_VALUE 32'h0000_5a01

// time of the power-ok filter, in ns, and derived cycles at 4 ns
`define SVD_PCLK_NS 4
`define SVD_POK_FILTER_NS 40
`define SVD_POK_CYCLES ((`SVD_POK_FILTER_NS + `SVD_PCLK_NS - 1) / `SVD_PCLK_NS)

`endif

// ==== rtl/svd_pkg.sv ====
// types shared by the serial voltage link decoder
// assumes svd_map.svh is on the include path
package svd_pkg;
   `include "svd_map.svh"

   typedef enum logic [1:0] {
      svd_idle,
      svd_shift,
      svd_wait_stop
   } svd_link_state_t;

   // settings held for one regulator output
   typedef struct packed {
      logic [7:0] code;
      logic ps0_n;
      logic ps1_n;
      logic telemetry;
      logic [2:0] ll_trim;
      logic [1:0] ofs_trim;
   } svd_output_t;
endpackage

// ==== rtl/svd_decoder.sv ====
// serial voltage link command decoder with apb register access
// assumes a host master drives the link clock; link clock may stop
// between frames; data line is open drain with an external pull-up
// limitation: start to first rising link clock edge must exceed about
// three pclk periods, the time taken to see start and release the link
`timescale 1ns/1ps

// Summary of operation
// RULE_01: three bytes, header 11000, acks 9/18/27
// RULE_02: bit 6 targets core output
// RULE_03: bit 7 targets northbridge output
// RULE_04: telemetry bit 21, trims 22-24, 25-26
// RULE_05: bit 10 level0, active low, drop phases
// RULE_06: bit 20 level1, active low, low power
// RULE_07: host frames start, bytes, acks, stop
// RULE_08: host uses send-byte transfer format
// RULE_09: data line never driven at acks
// RULE_10: apply command only after stop
// RULE_11: linear code, f8 and above off
// RULE_12: core 3-phase level0: ch2,3 off, ch1 diode
// RULE_13: nb 2-phase level0: ch2 off, ch1 diode
// RULE_14: level1 keeps reduced diode operation; code ignores level1, diode emulation and phase drop follow level0 only
// RULE_15: level0 wins; release returns full conduction
// RULE_16: accept commands only after power ok
// RULE_17: drop bad header or stopless packet
module svd_decoder
   import svd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_vid_clock_line,
   input wire logic serial_vid_data_line_in,
   output logic serial_vid_data_line_out,
   output logic serial_vid_data_line_oe,
   input wire logic host_power_ok_input,
   output logic [7:0] core_voltage_code,
   output logic core_output_off,
   output logic [2:0] core_phase_enable,
   output logic core_diode_emulation,
   output logic core_telemetry_function_bit,
   output logic [2:0] core_ll_trim,
   output logic [1:0] core_ofs_trim,
   output logic [7:0] nb_voltage_code,
   output logic nb_output_off,
   output logic [1:0] nb_phase_enable,
   output logic nb_diode_emulation,
   output logic nb_telemetry_function_bit,
   output logic [2:0] nb_ll_trim,
   output logic [1:0] nb_ofs_trim
);

   // link domain state, clocked by the host's link clock
   typedef struct packed {
      svd_link_state_t st;
      logic [4:0] cnt;
      logic [26:0] sh;
      logic [26:0] pkt;
      logic pkt_tgl;
   } svd_link_regs_t;

   // pclk domain state
   typedef struct packed {
      logic [2:0] pok_sync;
      logic [3:0] pok_cnt;
      logic pok;
      logic [1:0] sda_sync;
      logic [1:0] scl_sync;
      logic sda_q;
      logic scl_q;
      logic [2:0] tgl_sync;
      logic stop_seen;
      logic armed;
      logic [26:0] pkt_hold;
      logic [26:0] last_pkt;
      logic [1:0] ctrl;
      logic [7:0] good_cnt;
      logic [7:0] bad_cnt;
      svd_output_t core;
      svd_output_t nb;
      // output terms kept in flip-flops, derived from the settings
      logic core_off;
      logic [2:0] core_ph;
      logic core_de;
      logic nb_off;
      logic [1:0] nb_ph;
      logic nb_de;
      logic [31:0] rdata;
   } svd_regs_t;

   svd_link_regs_t lk;
   svd_link_regs_t next_lk;
   svd_regs_t r;
   svd_regs_t next_r;

   // packet bit n (1..27) lives at pkt[27-n]
   function automatic logic pbit(input logic [26:0] p, input int n);
      pbit = p[27 - n];
   endfunction

   function automatic svd_output_t svd_extract(input logic [26:0] p);
      svd_output_t o;
      // RULE_01 code placement
      o.code = {pbit(p, 11), pbit(p, 12), pbit(p, 13), pbit(p, 14),
                pbit(p, 15), pbit(p, 16), pbit(p, 17), pbit(p, 19)};
      // RULE_05 level0 from bit 10
      o.ps0_n = pbit(p, 10);
      // RULE_06 level1 from bit 20
      o.ps1_n = pbit(p, 20);
      // RULE_04 telemetry and trims
      o.telemetry = pbit(p, 21);
      o.ll_trim = {pbit(p, 22), pbit(p, 23), pbit(p, 24)};
      o.ofs_trim = {pbit(p, 25), pbit(p, 26)};
      svd_extract = o;
   endfunction

   // RULE_17 fixed header pattern and zero bit 8
   function automatic logic svd_hdr_ok(input logic [26:0] p);
      logic [4:0] hdr;
      hdr = {pbit(p, 1), pbit(p, 2), pbit(p, 3), pbit(p, 4), pbit(p, 5)};
      svd_hdr_ok = (hdr == 5'(`SVD_HDR_PATTERN)) && !pbit(p, 8);
   endfunction

   function automatic logic svd_is_off(input logic [7:0] c);
      svd_is_off = (c >= `SVD_CODE_OFF_MIN);
   endfunction

   // RULE_12 core phases: level0 leaves only channel 1 switching
   function automatic logic [2:0] svd_core_phases(input logic ps0_n,
                                                 input logic three);
      if (!ps0_n) begin
         svd_core_phases = 3'b001;
      end else if (three) begin
         svd_core_phases = 3'b111;
      end else begin
         svd_core_phases = 3'b011;
      end
   endfunction

   // RULE_13 nb phases: level0 leaves only channel 1 switching
   function automatic logic [1:0] svd_nb_phases(input logic ps0_n,
                                               input logic two);
      if (!ps0_n) begin
         svd_nb_phases = 2'b01;
      end else if (two) begin
         svd_nb_phases = 2'b11;
      end else begin
         svd_nb_phases = 2'b01;
      end
   endfunction

   // a new power ok level is taken only after it has held for the whole
   // filter time, so a glitch neither opens nor drops the link
   function automatic logic [4:0] svd_pok_step(input logic level,
                                               input logic pok,
                                               input logic [3:0] cnt);
      logic [4:0] res;
      res = {pok, 4'd0};
      if (level != pok) begin
         if (cnt == 4'(`SVD_POK_CYCLES - 1)) begin
            res = {level, 4'd0};
         end else begin
            res = {pok, cnt + 4'd1};
         end
      end
      svd_pok_step = res;
   endfunction

   // register read word; unmapped offsets read as zero
   function automatic logic [31:0] svd_read_word(input logic [11:0] a,
                                                 input svd_regs_t s);
      logic [31:0] w;
      w = 32'h0;
      case (a)
         `SVD_CTRL_OFS: w = {30'h0, s.ctrl};
         `SVD_STAT_OFS: w = {16'h0, s.bad_cnt, s.good_cnt[5:0], s.armed,
                             s.pok};
         `SVD_CORE_OFS: w = {16'h0, s.core};
         `SVD_NB_OFS: w = {16'h0, s.nb};
         `SVD_RAW_OFS: w = {5'h0, s.last_pkt};
         `SVD_ID_OFS: w = `SVD_ID_VALUE;
         default: w = 32'h0;
      endcase
      svd_read_word = w;
   endfunction

   // the link side only counts bits and captures the frame; start and
   // stop are judged on pclk, which holds this logic in reset outside
   // an accepted frame, so a stalled link clock leaves no half frame
   always_comb begin
      next_lk = lk;
      case (lk.st)
         svd_idle: begin
            // first rising edge after release carries packet bit 1
            next_lk.st = svd_shift;
            next_lk.sh = {lk.sh[25:0], serial_vid_data_line_in};
            next_lk.cnt = 5'd1;
         end
         svd_shift: begin
            next_lk.sh = {lk.sh[25:0], serial_vid_data_line_in};
            next_lk.cnt = lk.cnt + 5'd1;
            // RULE_01 ack slots shift in like any other bit
            if (lk.cnt == 5'(`SVD_PKT_BITS - 1)) begin
               next_lk.pkt = {lk.sh[25:0], serial_vid_data_line_in};
               // level flag: the frame reset clears it again
               next_lk.pkt_tgl = 1'b1;
               next_lk.st = svd_wait_stop;
            end
         end
         svd_wait_stop: begin
            // clocks beyond bit 27 are ignored until stop
            next_lk.st = svd_wait_stop;
         end
         default: begin
            next_lk.st = svd_idle;
         end
      endcase
   end

   // reset from pclk: asserted at once, released while the link clock
   // is quiet after start, so no first bit is lost to a synchroniser
   logic link_rst_n;
   always_ff @(posedge serial_vid_clock_line or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lk <= '0;
      end else begin
         lk <= next_lk;
      end
   end

   // start and stop conditions seen on synchronised pins
   logic start_cond;
   logic stop_cond;
   logic scl_high;
   logic sda_fall;
   logic sda_rise;
   // a change of data while the clock is high is a start or stop,
   // never data; both pins pass the same two flip-flops
   assign scl_high = r.scl_sync[1] & r.scl_q;
   assign sda_fall = r.sda_q & ~r.sda_sync[1];
   assign sda_rise = ~r.sda_q & r.sda_sync[1];
   assign start_cond = scl_high & sda_fall;
   assign stop_cond = scl_high & sda_rise;
   // link logic released only inside a frame after power ok
   // RULE_16 gate on power ok
   assign link_rst_n = presetn & r.armed & r.pok;

   logic pkt_new;
   // rising edge of the frame flag; the frame word is stable by then
   assign pkt_new = r.tgl_sync[1] & ~r.tgl_sync[2];

   always_comb begin
      next_r = r;
      next_r.pok_sync = {r.pok_sync[1:0], host_power_ok_input};
      {next_r.pok, next_r.pok_cnt} = svd_pok_step(r.pok_sync[2], r.pok,
                                                  r.pok_cnt);

      next_r.sda_sync = {r.sda_sync[0], serial_vid_data_line_in};
      next_r.scl_sync = {r.scl_sync[0], serial_vid_clock_line};
      next_r.sda_q = r.sda_sync[1];
      next_r.scl_q = r.scl_sync[1];
      next_r.tgl_sync = {r.tgl_sync[1:0], lk.pkt_tgl};
      if (pkt_new) begin
         next_r.pkt_hold = lk.pkt;
         next_r.stop_seen = 1'b1;
      end
      if (start_cond && r.pok) begin
         next_r.armed = 1'b1;
         next_r.stop_seen = 1'b0;
      end
      // RULE_10 act on stop
      if (stop_cond && r.armed) begin
         next_r.armed = 1'b0;
         next_r.stop_seen = 1'b0;
         // RULE_17 drop stopless or partial frames
         if (r.stop_seen) begin
            next_r.last_pkt = r.pkt_hold;
            // RULE_17 header check
            if (svd_hdr_ok(r.pkt_hold)) begin
               next_r.good_cnt = r.good_cnt + 8'd1;
               // RULE_02 core select
               if (pbit(r.pkt_hold, 6)) begin
                  next_r.core = svd_extract(r.pkt_hold);
               end
               // RULE_03 northbridge select
               if (pbit(r.pkt_hold, 7)) begin
                  next_r.nb = svd_extract(r.pkt_hold);
               end
            end else begin
               next_r.bad_cnt = r.bad_cnt + 8'd1;
            end
         end else begin
            next_r.bad_cnt = r.bad_cnt + 8'd1;
         end
      end
      // RULE_16 drop frame when power ok falls
      if (!r.pok) begin
         next_r.armed = 1'b0;
         next_r.stop_seen = 1'b0;
      end
      if (psel && penable && pwrite && paddr == `SVD_CTRL_OFS) begin
         next_r.ctrl = pwdata[1:0];
      end

      // RULE_11 off codes
      next_r.core_off = svd_is_off(next_r.core.code);
      next_r.nb_off = svd_is_off(next_r.nb.code);
      // RULE_12 RULE_14 RULE_15 level0 alone governs the phase drop
      next_r.core_de = ~next_r.core.ps0_n;
      next_r.core_ph = svd_core_phases(next_r.core.ps0_n,
                                       next_r.ctrl[`SVD_CTRL_CORE3PH]);
      // RULE_13 nb phase drop
      next_r.nb_de = ~next_r.nb.ps0_n;
      next_r.nb_ph = svd_nb_phases(next_r.nb.ps0_n,
                                   next_r.ctrl[`SVD_CTRL_NB2PH]);

      next_r.rdata = svd_read_word(paddr, r);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.ctrl <= 2'(`SVD_CTRL_RESET);
         r.core.code <= `SVD_CODE_RESET;
         r.core.ps0_n <= 1'b1;
         r.core.ps1_n <= 1'b1;
         r.nb.code <= `SVD_CODE_RESET;
         r.nb.ps0_n <= 1'b1;
         r.nb.ps1_n <= 1'b1;
         r.core_ph <= `SVD_CORE_PH_RESET;
         r.nb_ph <= `SVD_NB_PH_RESET;
      end else begin
         r <= next_r;
      end
   end

   // apb: zero wait states; read word registered from the address
   logic unmapped;
   assign unmapped = paddr[11:5] != 7'h0 || paddr[1:0] != 2'b00 ||
                     paddr[4:2] > 3'd5;
   assign pready = 1'b1;
   assign prdata = r.rdata;
   assign pslverr = psel & penable & unmapped;

   // RULE_09 never drive data line
   assign serial_vid_data_line_out = 1'b0;
   assign serial_vid_data_line_oe = 1'b0;

   assign core_voltage_code = r.core.code;
   assign core_output_off = r.core_off;
   assign core_diode_emulation = r.core_de;
   assign core_phase_enable = r.core_ph;
   assign core_telemetry_function_bit = r.core.telemetry;
   assign core_ll_trim = r.core.ll_trim;
   assign core_ofs_trim = r.core.ofs_trim;

   assign nb_voltage_code = r.nb.code;
   assign nb_output_off = r.nb_off;
   assign nb_diode_emulation = r.nb_de;
   assign nb_phase_enable = r.nb_ph;
   assign nb_telemetry_function_bit = r.nb.telemetry;
   assign nb_ll_trim = r.nb.ll_trim;
   assign nb_ofs_trim = r.nb.ofs_trim;

endmodule

// ==== verification/svd_host_model.sv ====
// host model: serial master that frames packets on the link
// assumes a pull-up on the data line; link clock idles high
`timescale 1ns/1ps
module svd_host_model (
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic send(input logic [26:0] p, input int n);
      #1.3 sda = 1'b0;
      #16;
      for (int i = 26; i > 26 - n; i--) begin
         scl = 1'b0;
         #8 sda = p[i];
         #8 scl = 1'b1;
         #16;
      end
      scl = 1'b0;
      #8 sda = 1'b0;
      #8 scl = 1'b1;
      #8 sda = 1'b1;
      #16;
   endtask
endmodule

// ==== verification/svd_decoder_properties.sv ====
// concurrent checks on the decoder ports
// assumes one pclk domain; bound into every svd_decoder
`timescale 1ns/1ps
module svd_decoder_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic serial_vid_clock_line,
   input wire logic serial_vid_data_line_in,
   input wire logic serial_vid_data_line_oe,
   input wire logic host_power_ok_input,
   input wire logic [7:0] core_voltage_code,
   input wire logic core_output_off,
   input wire logic [2:0] core_phase_enable,
   input wire logic core_diode_emulation,
   input wire logic [7:0] nb_voltage_code,
   input wire logic nb_output_off,
   input wire logic [1:0] nb_phase_enable,
   input wire logic nb_diode_emulation
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [17:0] watched;
   assign watched = {core_voltage_code, nb_voltage_code,
      core_diode_emulation, nb_diode_emulation};
   chk_data_released:
      assert property (!serial_vid_data_line_oe) else $error("data driven");
   chk_core_off:
      assert property (core_output_off == (core_voltage_code >= 8'hf8))
      else $error("core off flag wrong");
   chk_nb_off:
      assert property (nb_output_off == (nb_voltage_code >= 8'hf8))
      else $error("nb off flag wrong");
   chk_core_drop:
      assert property (core_diode_emulation |-> core_phase_enable == 3'b001)
      else $error("core phases not dropped");
   chk_nb_drop:
      assert property (nb_diode_emulation |-> nb_phase_enable == 2'b01)
      else $error("nb phases not dropped");
   chk_full_phase:
      assert property (!core_diode_emulation |-> &core_phase_enable[1:0])
      else $error("core not full conduction");
   chk_after_stop:
      assert property ($changed(watched) |->
         $past(serial_vid_clock_line && serial_vid_data_line_in))
      else $error("settings changed inside a frame");
   chk_power_gate:
      assert property ($changed(watched) |-> $past(host_power_ok_input, 8))
      else $error("settings changed without power ok");
endmodule
bind svd_decoder svd_decoder_properties u_props (.*);

// ==== verification/tb.sv ====
// self-checking bench for the serial voltage link decoder
// assumes the host model frames packets; pull-up on the data line
`timescale 1ns/1ps
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, host_power_ok_input = 1'b0, host_sda;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, serial_vid_clock_line;
   logic serial_vid_data_line_out, serial_vid_data_line_oe;
   logic [7:0] core_voltage_code, nb_voltage_code;
   logic [2:0] core_phase_enable, core_ll_trim, nb_ll_trim;
   logic [1:0] core_ofs_trim, nb_ofs_trim, nb_phase_enable;
   logic core_output_off, core_diode_emulation, core_telemetry_function_bit;
   logic nb_output_off, nb_diode_emulation, nb_telemetry_function_bit;
   logic [18:0] ec = 19'h00380;
   logic [17:0] en = 18'h00180;
   int errors = 0, num_checks = 0, cycles = 0;
   // open drain: low wins, otherwise the pull-up
   wire serial_vid_data_line_in = host_sda &
      !(serial_vid_data_line_oe & !serial_vid_data_line_out);
   wire [18:0] cv = {core_voltage_code, core_output_off, core_phase_enable,
      core_diode_emulation, core_telemetry_function_bit, core_ll_trim,
      core_ofs_trim};
   wire [17:0] nv = {nb_voltage_code, nb_output_off, nb_phase_enable,
      nb_diode_emulation, nb_telemetry_function_bit, nb_ll_trim, nb_ofs_trim};
   svd_decoder u_dut (.*);
   svd_host_model u_host (.scl(serial_vid_clock_line), .sda(host_sda));
   always #2 pclk = ~pclk;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         give_verdict;
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [26:0] pkt(input logic c, n, input logic [7:0] v,
      input logic p0, p1, t, input logic [2:0] ll, input logic [1:0] o);
      return {5'b11000, c, n, 2'b01, p0, v[7:1], 1'b1, v[0], p1, t, ll, o,
         1'b1};
   endfunction
   task automatic run(input logic [26:0] p, input int n);
      u_host.send(p, n);
      repeat (20) @(posedge pclk);
      chk("core settings", 32'(cv), 32'(ec));
      chk("nb settings", 32'(nv), 32'(en));
   endtask
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk("ctrl", r, 32'h3);
      apb(1'b0, 12'h020, 32'h0, r, e);
      chk("unmapped error", {31'h0, e}, 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_nopok;
      run(pkt(1, 1, 8'h40, 0, 0, 1, 3'b111, 2'b11), 27);
      $display("t_nopok done");
   endtask
   task automatic t_core;
      ec = {8'h80, 1'b0, 3'b001, 1'b1, 1'b1, 3'b101, 2'b10};
      run(pkt(1, 0, 8'h80, 0, 1, 1, 3'b101, 2'b10), 27);
      $display("t_core done");
   endtask
   task automatic t_both;
      ec = {8'hf8, 1'b1, 3'b111, 1'b0, 1'b0, 3'b011, 2'b01};
      en = {8'hf8, 1'b1, 2'b11, 1'b0, 1'b0, 3'b011, 2'b01};
      run(pkt(1, 1, 8'hf8, 1, 0, 0, 3'b011, 2'b01), 27);
      $display("t_both done");
   endtask
   task automatic t_nb;
      en = {8'hf7, 1'b0, 2'b01, 1'b1, 1'b1, 3'b111, 2'b11};
      run(pkt(0, 1, 8'hf7, 0, 0, 1, 3'b111, 2'b11), 27);
      $display("t_nb done");
   endtask
   task automatic t_bad;
      logic [26:0] p;
      p = pkt(1, 1, 8'h11, 1, 1, 1, 3'b100, 2'b00);
      run(p ^ 27'h4000000, 27);
      run(p | 27'h0080000, 27);
      run(p, 20);
      $display("t_bad done");
   endtask
   task automatic t_ctrl;
      logic [31:0] r;
      logic e;
      apb(1'b1, 12'h000, 32'h0, r, e);
      chk("core phases", 32'(core_phase_enable), 32'h3);
      chk("nb phases", 32'(nb_phase_enable), 32'h1);
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk("ctrl readback", r, 32'h0);
      apb(1'b0, 12'h004, 32'h0, r, e);
      chk("status counts", r, 32'h0000_030d);
      $display("t_ctrl done");
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_nopok;
      host_power_ok_input <= 1'b1;
      repeat (20) @(posedge pclk);
      t_core;
      t_both;
      t_nb;
      t_bad;
      t_ctrl;
      give_verdict;
   end
endmodule
